// ===== sbc_config_diag_encoder_tb_top.sv
// self-checking bench for the configuration and diagnostic encoder
`timescale 1ns/10ps
module sbc_config_diag_encoder_tb_top;
  // expected outcome of one frame
  typedef struct {
    logic [9:0] sdo;
    logic [9:0] mask;
    logic [2:0] sel;
    logic [4:0] comm;
    logic [7:0] wdog;
    logic [1:0] thr;
    logic wd2fb;
  } sbcd_exp_t;
  localparam logic [5:0] EV_RS = 6'h20;
  localparam logic [5:0] EV_FB = 6'h10;
  localparam logic [5:0] EV_OFF = 6'h08;
  localparam logic [5:0] EV_LV = 6'h04;
  localparam logic [5:0] EV_WF = 6'h02;
  localparam logic [5:0] EV_OK = 6'h01;
  logic clk, nrst, restart_evt, fallback_evt, fallback_switch_off;
  logic leave_sleep_or_failsafe, wd_fail, wd_ok, test_pin, int_strap;
  logic [1:0] restart_code, reset_thresh;
  logic [2:0] fallback_code, sdo_select;
  sbcd_pkg::sbcd_frame_t frame;
  sbcd_pkg::sbcd_comm_t comm_cfg;
  sbcd_pkg::sbcd_wdog_t wdog_cfg;
  logic [10:0] wd_period_ms;
  logic wd_fail_to_fallback, sw_dev_mode, wd_restart_req;
  logic wd_failsafe_req, fallback_on_req;
  logic [9:0] sdo_data;
  logic [4:0] comm_m;
  logic [7:0] wdog_m;
  logic [1:0] thr_m, rr_m;
  logic [2:0] fb_m;
  logic wd2fb_m, strap_m, tp_m;
  int bad_count = 0;
  int check_count = 0;
  sbcd_exp_t exp_q[$];

  sbcd_encoder u_dut (.clk, .nrst, .frame, .restart_evt, .restart_code,
    .fallback_evt, .fallback_code, .fallback_switch_off,
    .leave_sleep_or_failsafe, .wd_fail, .wd_ok, .test_pin, .int_strap,
    .comm_cfg, .wdog_cfg, .wd_period_ms, .reset_thresh,
    .wd_fail_to_fallback, .sw_dev_mode, .wd_restart_req, .wd_failsafe_req,
    .fallback_on_req, .sdo_data, .sdo_select);
  sbcd_host_model u_host (.clk(clk), .frm(frame));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] expv);
    check_count++;
    if (seen !== expv) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, expv, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // note the readback from the old state, then update the model and send
  task automatic frame_op(input logic [2:0] sel, input logic [9:0] f,
                          input logic ro, input logic bad_par);
    sbcd_exp_t e;
    e.sel = sel;
    e.mask = 10'h3ff;
    e.sdo = {5'h00, comm_m};
    // watchdog readback carries the checksum of its stored bits
    if (sel == sbcd_pkg::SEL_WDOG) e.sdo = {1'b0, ^wdog_m, wdog_m};
    if (sel == sbcd_pkg::SEL_SBC_CFG) e.sdo = {7'h00, wd2fb_m, thr_m};
    if (sel == sbcd_pkg::SEL_DIAG) begin
      e.sdo = {2'h0, rr_m, fb_m, tp_m, wd2fb_m, strap_m};
    end
    if (!ro) begin
      if (sel == sbcd_pkg::SEL_COMM) comm_m = f[4:0];
      if (sel == sbcd_pkg::SEL_WDOG && !bad_par) begin
        wdog_m = {f[7], 1'b1, f[5:0]};
      end
      if (sel == sbcd_pkg::SEL_SBC_CFG) begin
        if (f[1:0] != sbcd_pkg::THR_INVALID) thr_m = f[1:0];
        wd2fb_m = f[2];
      end
    end else if (sel == sbcd_pkg::SEL_DIAG) begin
      rr_m = sbcd_pkg::RC_NONE;
    end
    e.comm = comm_m;
    e.wdog = wdog_m;
    e.thr = thr_m;
    e.wd2fb = wd2fb_m;
    exp_q.push_back(e);
    u_host.send(sel, f, ro, bad_par);
  endtask : frame_op

  // read-only diagnosis read with junk in the payload
  task automatic diag;
    frame_op(sbcd_pkg::SEL_DIAG, 10'($urandom()), 1'b1, 1'b0);
  endtask : diag

  // pulse events for one cycle and gather the failure actions
  task automatic ev(input logic [5:0] m, input logic [1:0] rc,
                    input logic [2:0] fc, output logic [2:0] seen);
    @(negedge clk);
    {restart_evt, fallback_evt, fallback_switch_off,
     leave_sleep_or_failsafe, wd_fail, wd_ok} = m;
    restart_code = rc;
    fallback_code = fc;
    seen = 3'h0;
    repeat (3) begin
      @(negedge clk);
      {restart_evt, fallback_evt, fallback_switch_off,
       leave_sleep_or_failsafe, wd_fail, wd_ok} = 6'h00;
      seen = seen | {wd_failsafe_req, fallback_on_req, wd_restart_req};
    end
  endtask : ev

  // ****************************************************************
  // processes
  // ****************************************************************
  // clock source
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // frame monitor: oldest note against outputs the cycle after a frame
  initial begin
    sbcd_exp_t e;
    logic [9:0] s;
    forever begin
      @(posedge clk);
      if (frame.valid === 1'b1) begin
        @(negedge clk);
        e = exp_q.pop_front();
        s = sdo_data & e.mask;
        check("sdo_data", 16'(s), 16'(e.sdo & e.mask));
        check("sdo_select", 16'(sdo_select), 16'(e.sel));
        check("comm_cfg", 16'(comm_cfg), 16'(e.comm));
        check("wdog_cfg", 16'(wdog_cfg), 16'(e.wdog));
        check("reset_thresh", 16'(reset_thresh), 16'(e.thr));
        check("wd2fb", 16'(wd_fail_to_fallback), 16'(e.wd2fb));
      end
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("Error run exceeded its cycle limit");
    complete_run();
  end

  // main sequence
  initial begin
    logic [2:0] seen;
    logic [4:0] n;
    logic [4:0] tbl[7] = '{5'h00, 5'h01, 5'h0f, 5'h10, 5'h11, 5'h1e, 5'h1f};
    logic rb;
    logic [9:0] f;
    logic [15:0] pexp;
    logic [2:0] fs;
    {restart_evt, fallback_evt, fallback_switch_off,
     leave_sleep_or_failsafe, wd_fail, wd_ok} = 6'h00;
    restart_code = 2'h0;
    fallback_code = 3'h0;
    test_pin = 1'b0;
    nrst = 1'b0;
    void'($urandom(9747));
    strap_m = 1'($urandom());
    int_strap = strap_m;
    fs = {strap_m, 1'b1, ~strap_m};
    comm_m = {sbcd_pkg::RST_LIN_SLOPE, sbcd_pkg::RST_CELL_MODE,
              sbcd_pkg::RST_CELL_MODE};
    wdog_m = {sbcd_pkg::RST_WD_TOW, sbcd_pkg::RST_WD_RSV,
              sbcd_pkg::RST_WD_EN, sbcd_pkg::RST_WD_PER};
    thr_m = sbcd_pkg::RST_THRESH;
    wd2fb_m = sbcd_pkg::RST_WD2FB;
    rr_m = sbcd_pkg::RC_NONE;
    fb_m = sbcd_pkg::FB_NONE;
    tp_m = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    repeat (5) @(negedge clk);
    // every cell mode pair, defaults seen in the first readback
    for (int i = 0; i < 16; i++) begin
      rb = 1'($urandom());
      frame_op(sbcd_pkg::SEL_COMM, {5'h00, rb, 4'(i)}, 0, 0);
    end
    frame_op(sbcd_pkg::SEL_COMM, 10'h3ff ^ {5'h00, comm_m}, 1, 0);
    frame_op(sbcd_pkg::SEL_DIAG, 10'h3ff, 0, 0);
    // period boundaries and random codes, then a corrupt checksum
    for (int i = 0; i < 10; i++) begin
      n = (i < 7) ? tbl[i] : 5'($urandom());
      f = {2'h0, 1'($urandom()), 1'b0, 1'($urandom()), n};
      frame_op(sbcd_pkg::SEL_WDOG, f, 0, 0);
      pexp = (n < 16) ? 16'((n + 1) * 16) : 16'(n * 48 - 464);
      repeat (2) @(negedge clk);
      check("wd_period_ms", 16'(wd_period_ms), pexp);
    end
    frame_op(sbcd_pkg::SEL_WDOG, 10'h0aa ^ {2'h0, wdog_m}, 0, 1);
    // thresholds, the invalid code keeping the previous one
    for (int i = 0; i < 6; i++) begin
      f = {7'h00, 1'(i), 2'(i + 1)};
      frame_op(sbcd_pkg::SEL_SBC_CFG, f, 0, 0);
    end
    frame_op(sbcd_pkg::SEL_SBC_CFG, {7'h00, 1'b1, 2'h3}, 0, 0);
    // restart reasons, read out and cleared by the read
    for (int i = 1; i < 4; i++) begin
      ev(EV_RS, 2'(i), 3'h0, seen);
      rr_m = 2'(i);
      diag();
    end
    ev(EV_RS, 2'h3, 3'h0, seen);
    ev(EV_LV, 2'h0, 3'h0, seen);
    rr_m = sbcd_pkg::RC_NONE;
    diag();
    // fallback causes; the reserved code is dropped
    for (int i = 1; i < 8; i++) begin
      ev(EV_FB, 2'h0, 3'(i), seen);
      if (3'(i) != sbcd_pkg::FB_RESERVED) fb_m = 3'(i);
      diag();
    end
    ev(EV_OFF, 2'h0, 3'h0, seen);
    fb_m = sbcd_pkg::FB_NONE;
    diag();
    // two failures needed; a good trigger restarts the count
    ev(EV_WF, 2'h0, 3'h0, seen);
    check("wd_first", 16'(seen), 16'h0001);
    rr_m = sbcd_pkg::RC_WD_FIRST;
    diag();
    ev(EV_OK, 2'h0, 3'h0, seen);
    ev(EV_WF, 2'h0, 3'h0, seen);
    check("wd_after_ok", 16'(seen), 16'h0001);
    rr_m = sbcd_pkg::RC_WD_FIRST;
    ev(EV_WF, 2'h0, 3'h0, seen);
    check("wd_second", 16'(seen), 16'(fs));
    fb_m = sbcd_pkg::FB_WD_TWO;
    diag();
    // single failure suffices once the bit is cleared
    frame_op(sbcd_pkg::SEL_SBC_CFG, {7'h00, 1'b0, thr_m}, 0, 0);
    ev(EV_WF, 2'h0, 3'h0, seen);
    check("wd_single", 16'(seen), 16'(fs));
    fb_m = sbcd_pkg::FB_WD_ONE;
    diag();
    // development mode swallows failures
    @(negedge clk) test_pin = 1'b1;
    tp_m = 1'b1;
    repeat (4) @(negedge clk);
    check("sw_dev_mode", 16'(sw_dev_mode), 16'h0001);
    ev(EV_WF, 2'h0, 3'h0, seen);
    check("wd_dev", 16'(seen), 16'h0000);
    diag();
    repeat (3) @(negedge clk);
    check("queue_left", 16'(exp_q.size()), 16'h0000);
    complete_run();
  end
endmodule : sbc_config_diag_encoder_tb_top

// ===== sbcd_encoder.sv
// configuration and diagnostic field encoder of the system base device
//
// Function
// - select 101 is comm set-up; slope bit resets to 1, sets low slope
// - can cell mode resets 00: off, wake, receive only, normal
// - lin cell mode resets 00: off, wake, receive only, normal
// - select 110 is watchdog; time-out and enable bits reset to 1
// - checksum is xor of bits 13..6; mismatch discards the write
// - select 111 takes no settings; output returns diagnosis encodings
// - diagnostic encodings only appear on output, ignored as input
// - threshold 01/10/11 selects level; 00 keeps previous threshold
// - period codes 0..15 give (n+1)*16 ms; default 01111 is 256 ms
// - period codes 16..31 give n*48-464 ms, up to 1024 ms
// - restart reason 2-bit code reports cause of last restart
// - restart reason clears on read-only read or sleep/fail-safe exit
// - 3-bit fallback cause code reports limp-home reason; 111 reserved
// - fallback cause returns to 000 when host switches limp home off
// - host reads strap configuration, test pin and fail-to-fallback bit
// - readout 000..011 encodes supply behaviour after one or two failures
// - readout top bit set is development mode; failures do nothing
// - unwritten fields keep defaults; current values go to serial output
// - fail-to-fallback bit resets 1: two failures needed, else one
`timescale 1ns/10ps
module sbcd_encoder (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // received frames from the shift logic
  input wire sbcd_pkg::sbcd_frame_t frame,
  // events from the supervisor
  input wire logic restart_evt,
  input wire logic [1:0] restart_code,
  input wire logic fallback_evt,
  input wire logic [2:0] fallback_code,
  input wire logic fallback_switch_off,
  input wire logic leave_sleep_or_failsafe,
  input wire logic wd_fail,
  input wire logic wd_ok,
  // pins
  input wire logic test_pin,
  input wire logic int_strap,
  // configuration outputs
  output sbcd_pkg::sbcd_comm_t comm_cfg,
  output sbcd_pkg::sbcd_wdog_t wdog_cfg,
  output logic [10:0] wd_period_ms,
  output logic [1:0] reset_thresh,
  output logic wd_fail_to_fallback,
  output logic sw_dev_mode,
  // watchdog failure actions
  output logic wd_restart_req,
  output logic wd_failsafe_req,
  output logic fallback_on_req,
  // serial output word
  output logic [9:0] sdo_data,
  output logic [2:0] sdo_select
);

  // ****************************************************************
  // reset release and pin synchronisation
  // ****************************************************************
  logic rst_n_q1;
  logic rst_n;
  logic [1:0] pins_s;

  // async assert, synchronous release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_n_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_n_q1 <= 1'b1;
      rst_n <= rst_n_q1;
    end
  end

  sbcd_sync2 #(.WIDTH(2)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({test_pin, int_strap}),
    .sync_out(pins_s)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic par_ok(input logic [15:0] d);
    par_ok = (^d[sbcd_pkg::PAR_HI:sbcd_pkg::PAR_LO])
      == d[sbcd_pkg::WD_PAR_BIT];
  endfunction : par_ok

  function automatic logic [10:0] period_ms(input logic [4:0] n);
    logic [10:0] n11;
    n11 = {6'h00, n};
    if (int'(n) < sbcd_pkg::PER_SPLIT) begin
      period_ms = 11'((n11 + 11'h001) * 11'(sbcd_pkg::PER_STEP_LO_MS));
    end else begin
      period_ms = 11'(n11 * 11'(sbcd_pkg::PER_STEP_HI_MS)
        - 11'(sbcd_pkg::PER_OFFS_HI_MS));
    end
  endfunction : period_ms

  // ****************************************************************
  // frame decode
  // ****************************************************************
  logic [2:0] sel;
  logic wr_ok;
  logic wr_comm;
  logic wr_wdog;
  logic wr_cfg;
  logic rd_diag;

  assign sel = frame.data[sbcd_pkg::SEL_LSB +: 3];
  // writes need a whole frame that is not read-only
  assign wr_ok = frame.valid && !frame.read_only;
  assign wr_comm = wr_ok && (sel == sbcd_pkg::SEL_COMM);
  assign wr_wdog = wr_ok && (sel == sbcd_pkg::SEL_WDOG)
    && par_ok(frame.data);
  assign wr_cfg = wr_ok && (sel == sbcd_pkg::SEL_SBC_CFG);
  // select 111 carries nothing in: only a read-only frame acts on it
  assign rd_diag = frame.valid && frame.read_only
    && (sel == sbcd_pkg::SEL_DIAG);

  // ****************************************************************
  // communication set-up register
  // ****************************************************************
  sbcd_pkg::sbcd_comm_t comm_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comm_q.lin_low_slope <= sbcd_pkg::RST_LIN_SLOPE;
      comm_q.can_cell_mode <= sbcd_pkg::CELL_OFF;
      comm_q.lin_cell_mode <= sbcd_pkg::CELL_OFF;
    end else if (wr_comm) begin
      comm_q.lin_low_slope <= frame.data[sbcd_pkg::LIN_SLOPE_BIT];
      comm_q.can_cell_mode <= sbcd_pkg::sbcd_cell_mode_t'(
        frame.data[sbcd_pkg::CAN_MODE_LSB +: 2]);
      comm_q.lin_cell_mode <= sbcd_pkg::sbcd_cell_mode_t'(
        frame.data[sbcd_pkg::LIN_MODE_LSB +: 2]);
    end
  end

  // ****************************************************************
  // watchdog register
  // ****************************************************************
  sbcd_pkg::sbcd_wdog_t wdog_q;

  // a bad checksum leaves the last valid settings in place
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_q.wd_timeout_or_window <= sbcd_pkg::RST_WD_TOW;
      wdog_q.reserved_one <= sbcd_pkg::RST_WD_RSV;
      wdog_q.wd_enable <= sbcd_pkg::RST_WD_EN;
      wdog_q.period_code <= sbcd_pkg::RST_WD_PER;
    end else if (wr_wdog) begin
      wdog_q.wd_timeout_or_window <= frame.data[sbcd_pkg::WD_TOW_BIT];
      wdog_q.reserved_one <= sbcd_pkg::RST_WD_RSV;
      wdog_q.wd_enable <= frame.data[sbcd_pkg::WD_EN_BIT];
      wdog_q.period_code <=
        frame.data[sbcd_pkg::PER_MSB:sbcd_pkg::PER_LSB];
    end
  end

  // period decode is registered so it tracks the stored code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_period_ms <= 11'h100;
    end else begin
      wd_period_ms <= period_ms(wdog_q.period_code);
    end
  end

  // ****************************************************************
  // threshold and fail-to-fallback fields of the set-up register
  // ****************************************************************
  logic [1:0] thresh_q;
  logic wd2fb_q;
  logic [1:0] thr_in;

  assign thr_in = frame.data[sbcd_pkg::THR_LSB +: 2];

  // code 00 is rejected so the old level stays
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thresh_q <= sbcd_pkg::RST_THRESH;
      wd2fb_q <= sbcd_pkg::RST_WD2FB;
    end else if (wr_cfg) begin
      if (thr_in != sbcd_pkg::THR_INVALID) begin
        thresh_q <= thr_in;
      end
      wd2fb_q <= frame.data[sbcd_pkg::WD2FB_BIT];
    end
  end

  // ****************************************************************
  // strap capture
  // ****************************************************************
  logic [1:0] strap_wait_q;
  logic strap_q;

  // last capture once the synchroniser holds the pin level, not its reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait_q <= 2'h0;
      strap_q <= 1'b0;
    end else if (strap_wait_q != 2'h3) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      strap_q <= pins_s[0];
    end
  end

  logic [2:0] strap_read;
  // b2 test pin, b1 failures needed, b0 fail-safe instead of restart
  assign strap_read = {pins_s[1], wd2fb_q, strap_q};
  assign sw_dev_mode = strap_read[2];

  // ****************************************************************
  // watchdog failure handling
  // ****************************************************************
  logic [1:0] fails_q;
  logic [1:0] fails_need;
  logic fail_hit;

  assign fails_need = wd2fb_q ? 2'h2 : 2'h1;
  // development mode swallows every failure
  assign fail_hit = wd_fail && !sw_dev_mode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fails_q <= 2'h0;
    end else if (fail_hit) begin
      fails_q <= (fails_q + 2'h1 >= fails_need) ? 2'h0 : fails_q + 2'h1;
    end else if (wd_ok) begin
      fails_q <= 2'h0;
    end
  end

  logic reach;
  assign reach = fail_hit && (fails_q + 2'h1 >= fails_need);

  // action pulses registered one cycle after the failure
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fallback_on_req <= 1'b0;
      wd_failsafe_req <= 1'b0;
      wd_restart_req <= 1'b0;
    end else begin
      fallback_on_req <= reach;
      wd_failsafe_req <= reach && strap_q;
      wd_restart_req <= fail_hit && !(reach && strap_q);
    end
  end

  // ****************************************************************
  // restart reason
  // ****************************************************************
  logic [1:0] restart_q;

  // a new cause wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_q <= sbcd_pkg::RC_NONE;
    end else if (fail_hit && !reach) begin
      restart_q <= sbcd_pkg::RC_WD_FIRST;
    end else if (restart_evt) begin
      restart_q <= restart_code;
    end else if (rd_diag || leave_sleep_or_failsafe) begin
      restart_q <= sbcd_pkg::RC_NONE;
    end
  end

  // ****************************************************************
  // fallback cause
  // ****************************************************************
  logic [2:0] fb_q;

  // reserved code from the supervisor is ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_q <= sbcd_pkg::FB_NONE;
    end else if (reach) begin
      fb_q <= wd2fb_q ? sbcd_pkg::FB_WD_TWO : sbcd_pkg::FB_WD_ONE;
    end else if (fallback_evt && fallback_code != sbcd_pkg::FB_RESERVED) begin
      fb_q <= fallback_code;
    end else if (fallback_switch_off) begin
      fb_q <= sbcd_pkg::FB_NONE;
    end
  end

  // ****************************************************************
  // serial output word
  // ****************************************************************
  logic [9:0] rd_mux;

  always_comb begin
    rd_mux = 10'h000;
    case (sel)
      sbcd_pkg::SEL_COMM: rd_mux = {5'h00, comm_q};
      sbcd_pkg::SEL_WDOG: rd_mux = {1'b0, ^wdog_q, wdog_q};
      sbcd_pkg::SEL_SBC_CFG: rd_mux = {7'h00, wd2fb_q, thresh_q};
      sbcd_pkg::SEL_DIAG: rd_mux = {2'h0, restart_q, fb_q,
        strap_read};
      default: rd_mux = 10'h000;
    endcase
  end

  // word captured at frame end, before the clear acts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_data <= 10'h000;
      sdo_select <= 3'h0;
    end else if (frame.valid) begin
      sdo_data <= rd_mux;
      sdo_select <= sel;
    end
  end

  assign comm_cfg = comm_q;
  assign wdog_cfg = wdog_q;
  assign reset_thresh = thresh_q;
  assign wd_fail_to_fallback = wd2fb_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence bad_wd_write_s;
    wr_ok && sel == sbcd_pkg::SEL_WDOG && !par_ok(frame.data);
  endsequence

  sequence two_fail_s;
    fail_hit && wd2fb_q && fails_q == 2'h1;
  endsequence

  wdog_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    bad_wd_write_s |=> $stable(wdog_q))
    else $error("watchdog changed on bad checksum");

  rsv_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    wdog_q.reserved_one)
    else $error("reserved watchdog bit not one");

  thr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cfg && thr_in == 2'h0 |=> thresh_q == $past(thresh_q))
    else $error("threshold changed on code 00");

  wd_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wdog_q.period_code == 5'h1f) [*2] |-> wd_period_ms == 11'd1024)
    else $error("top period not 1024 ms");

  rc_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_diag && !restart_evt && !fail_hit |=> restart_q == 2'h0)
    else $error("restart reason not cleared");

  fb_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    fallback_switch_off && !fallback_evt && !reach |=> fb_q == 3'h0)
    else $error("fallback cause not cleared");

  dev_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    wd_fail && sw_dev_mode |=> !fallback_on_req && !wd_restart_req)
    else $error("failure acted in development mode");

  two_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
    two_fail_s |=> fallback_on_req ##0 fb_q == 3'h3)
    else $error("second failure did not reach fallback");

  comm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_comm |=> $stable(comm_q))
    else $error("comm set-up changed without write");

endmodule : sbcd_encoder

// ===== sbcd_host_model.sv
// host-side frame source standing in for the microcontroller
`timescale 1ns/10ps
module sbcd_host_model (
  // clock
  input wire logic clk,
  // frame towards the encoder
  output sbcd_pkg::sbcd_frame_t frm
);
  // ****************************************************************
  // frame issue
  // ****************************************************************
  // idle value until the first frame
  initial begin
    frm = '0;
  end

  // one frame per call; released lines show inverted junk, not old data
  task automatic send(input logic [2:0] sel, input logic [9:0] f,
                      input logic ro, input logic bad_par);
    logic [15:0] d;
    d = {f, 3'h0, sel};
    if (sel == sbcd_pkg::SEL_WDOG) begin
      d[sbcd_pkg::WD_RSV_BIT] = 1'b1;
      d[sbcd_pkg::WD_PAR_BIT] = (^d[13:6]) ^ bad_par;
    end
    @(negedge clk);
    frm <= {1'b1, ro, d};
    @(negedge clk);
    frm <= {1'b0, ~ro, ~d};
  endtask : send
endmodule : sbcd_host_model

// ===== sbcd_pkg.sv
// shared constants and carrier types for the configuration/diagnostic encoder
package sbcd_pkg;

  // ****************************************************************
  // select codes
  // ****************************************************************
  localparam logic [2:0] SEL_SBC_CFG = 3'h4;
  localparam logic [2:0] SEL_COMM = 3'h5;
  localparam logic [2:0] SEL_WDOG = 3'h6;
  localparam logic [2:0] SEL_DIAG = 3'h7;

  // ****************************************************************
  // frame field positions
  // ****************************************************************
  localparam int SEL_LSB = 0;
  localparam int PER_LSB = 6;
  localparam int PER_MSB = 10;
  localparam int WD_EN_BIT = 11;
  localparam int WD_RSV_BIT = 12;
  localparam int WD_TOW_BIT = 13;
  localparam int WD_PAR_BIT = 14;
  localparam int PAR_LO = 6;
  localparam int PAR_HI = 13;
  localparam int LIN_MODE_LSB = 6;
  localparam int CAN_MODE_LSB = 8;
  localparam int LIN_SLOPE_BIT = 10;
  localparam int THR_LSB = 6;
  localparam int WD2FB_BIT = 8;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RST_LIN_SLOPE = 1'b1;
  localparam logic [1:0] RST_CELL_MODE = 2'h0;
  localparam logic RST_WD_TOW = 1'b1;
  localparam logic RST_WD_EN = 1'b1;
  localparam logic RST_WD_RSV = 1'b1;
  localparam logic [4:0] RST_WD_PER = 5'h0f;
  localparam logic [1:0] RST_THRESH = 2'h1;
  localparam logic RST_WD2FB = 1'b1;

  // ****************************************************************
  // encodings and period arithmetic
  // ****************************************************************
  localparam logic [1:0] THR_INVALID = 2'h0;
  localparam logic [1:0] RC_NONE = 2'h0;
  localparam logic [1:0] RC_WD_FIRST = 2'h2;
  localparam logic [2:0] FB_NONE = 3'h0;
  localparam logic [2:0] FB_WD_ONE = 3'h2;
  localparam logic [2:0] FB_WD_TWO = 3'h3;
  localparam logic [2:0] FB_RESERVED = 3'h7;
  localparam int PER_STEP_LO_MS = 16;
  localparam int PER_STEP_HI_MS = 48;
  localparam int PER_OFFS_HI_MS = 464;
  localparam int PER_SPLIT = 16;

  // cell operating modes
  typedef enum logic [1:0] {
    CELL_OFF = 2'h0,
    CELL_WAKE = 2'h1,
    CELL_RX_ONLY = 2'h2,
    CELL_NORMAL = 2'h3
  } sbcd_cell_mode_t;

  // one complete received frame from the shift logic
  typedef struct packed {
    logic valid;
    logic read_only;
    logic [15:0] data;
  } sbcd_frame_t;

  // communication set-up fields
  typedef struct packed {
    logic lin_low_slope;
    sbcd_cell_mode_t can_cell_mode;
    sbcd_cell_mode_t lin_cell_mode;
  } sbcd_comm_t;

  // watchdog set-up fields
  typedef struct packed {
    logic wd_timeout_or_window;
    logic reserved_one;
    logic wd_enable;
    logic [4:0] period_code;
  } sbcd_wdog_t;

endpackage : sbcd_pkg

// ===== sbcd_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sbcd_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sbcd_sync2
